// ==== logic/bmf_top.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Storage with mark and rewind
module bmf_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Control
	input wire logic clear_in,
	input wire logic mark_in,
	input wire logic rewind_in,
	// Fill side
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	// Drain side
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out,
	output logic [$clog2(DEPTH):0] count_out
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] DEPTH_P = (PW+1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW:0] wr_ptr;
		logic [PW:0] rd_ptr;
		logic [PW:0] mark_ptr;
	} bmf_fifo_st_t;

	bmf_fifo_st_t s_reg;
	bmf_fifo_st_t s_next;

	assign count_out = s_reg.wr_ptr - s_reg.rd_ptr;
	assign in_ready_out = (count_out != DEPTH_P);
	assign out_valid_out = (count_out != '0);
	assign out_data_out = s_reg.mem[s_reg.rd_ptr[PW-1:0]];

	always_comb begin
		s_next = s_reg;
		if (clear_in) begin
			s_next.wr_ptr = '0;
			s_next.rd_ptr = '0;
			s_next.mark_ptr = '0;
		end else begin
			if (in_valid_in && in_ready_out) begin
				s_next.mem[s_reg.wr_ptr[PW-1:0]] = in_data_in;
				s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
			end
			if (mark_in) begin
				s_next.mark_ptr = s_reg.rd_ptr;
			end
			// Rewind only while the marked words cannot have been overwritten
			if (rewind_in && ((s_reg.wr_ptr - s_reg.mark_ptr) <= DEPTH_P)) begin
				s_next.rd_ptr = s_reg.mark_ptr;
			end else if (out_ready_in && out_valid_out) begin
				s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule // bmf_fifo

// ==========================================================
// Bus-matching buffer
// Contract
// [RL1] Write and read port widths 36/18/9 latched from select pins at master reset.
// [RL2] Synchronous write stores a word on write-clock rise with write enable low.
// [RL3] Asynchronous write stores on write strobe rise; enable held low outside.
// [RL4] Synchronous read happens on read-clock rise with read enable low.
// [RL5] Asynchronous read happens on read strobe rise; enable held low outside.
// [RL6] With asynchronous reads user picks standard mode, chip select low, output enable.
// [RL7] Outputs float when sampled chip select or output enable is inactive.
// [RL8] Echo enable and clock follow read data; idle in asynchronous read mode.
// [RL9] Read and write clocks run at any rate independently of each other. Here each level must last at least one clk_in cycle.
// [RL10] Standard mode: first word shows only after an explicit read.
// [RL11] Fall-through: first word shows after three read-clock transitions; later need reads.
// [RL12] Timing mode latched from fall-through/serial pin at master reset.
// [RL13] Primary flags are empty/full or output/input ready; others always work.
// [RL14] Two offsets; one of eight defaults chosen at master reset.
// [RL15] Serial clock rise with serial enable and load select shifts one offset bit.
// [RL16] Write-clock rise with write enable and load select loads offsets in parallel.
// [RL17] Read-clock rise with read enable and load select shows offsets on outputs.
// [RL18] Master reset clears both pointers and latches the mode pins.
// [RL19] Partial reset clears pointers, keeps modes and offsets, flags then update.
// [RL20] Asynchronous flag timing: assert on one port's edge, release on the other's.
// [RL21] Synchronous flag timing: almost-empty on read edges, almost-full on write edges.
// [RL22] Flag timing mode latched from flag mode pin at master reset.
// [RL23] Narrow reads give most significant part first unless endian select high.
// [RL24] Mark records the read location; retransmit low restores the read pointer.
// [RL25] Writes while full and reads while empty are ignored.
// [RL26] Almost flags low when count or free space at or below offset.
module bmf_top import bmf_pkg::*; (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Resets and configuration straps
	input wire logic master_reset_n_in,
	input wire logic partial_reset_n_in,
	input wire logic input_width_sel_in,
	input wire logic output_width_sel_in,
	input wire logic bus_match_sel_in,
	input wire logic endian_sel_in,
	input wire logic flag_timing_sel_in,
	input wire logic write_port_sync_sel_in,
	input wire logic read_port_sync_sel_in,
	input wire logic default_offset_sel0_in,
	input wire logic default_offset_sel1_in,
	// Write port
	input wire logic write_clock_in,
	input wire logic write_enable_n_in,
	input wire logic write_strobe_in,
	input wire logic [WORD_W-1:0] data_in_in,
	// Read port
	input wire logic read_clock_in,
	input wire logic read_enable_n_in,
	input wire logic read_strobe_in,
	input wire logic read_chip_select_n_in,
	input wire logic output_enable_n_in,
	input wire logic mark_in,
	input wire logic retransmit_n_in,
	// Offset programming
	input wire logic load_select_n_in,
	input wire logic serial_clock_in,
	input wire logic serial_load_enable_n_in,
	input wire logic fall_through_or_serial_in_in,
	// Data out
	output logic [WORD_W-1:0] data_out_out,
	output logic data_out_oe_out,
	output logic echo_read_enable_n_out,
	output logic echo_read_clock_out,
	// Flags, all active low
	output logic empty_flag_n_out,
	output logic full_flag_n_out,
	output logic half_full_flag_n_out,
	output logic almost_empty_flag_n_out,
	output logic almost_full_flag_n_out
);
	typedef struct packed {
		bmf_cfg_t cfg;
		bmf_ofs_t ofs;
		logic [WORD_W-1:0] wr_acc;
		logic [1:0] wr_part;
		logic [WORD_W-1:0] hold;
		logic held;
		logic [1:0] rd_part;
		bmf_ft_t ft;
		logic [1:0] ft_trans;
		logic wclk_d;
		logic wstb_d;
		logic rclk_d;
		logic rstb_d;
		logic sclk_d;
		logic rcs_n;
		logic [WORD_W-1:0] dout;
		logic oe;
		logic echo_read_enable;
		logic echo_read_clock;
		logic ef;
		logic ff;
		logic hf;
		logic almost_empty_flag;
		logic almost_full_flag;
		logic rd_evt_d;
		logic wr_evt_d;
	} bmf_top_st_t;

	bmf_top_st_t s_reg;
	bmf_top_st_t s_next;

	logic wclk_rise;
	logic rclk_rise;
	logic rclk_turn;
	logic sclk_rise;
	logic wr_tick;
	logic rd_tick;
	logic ld;
	logic wr_edge;
	logic rd_edge;
	logic in_reset;
	logic push;
	logic pop;
	logic mark_req;
	logic rewind;
	logic clear;
	logic [WORD_W-1:0] wr_word;
	logic fifo_ready;
	logic fifo_valid;
	logic [WORD_W-1:0] fifo_data;
	logic [CNT_W-1:0] fifo_count;
	logic fifo_full;
	logic ae_cond;
	logic af_cond;

	// ==========================================================
	// Port events; all pins are sampled on clk_in, so each port clock level must last at least one clk_in cycle
	assign wclk_rise = write_clock_in & ~s_reg.wclk_d; // RL9
	assign rclk_rise = read_clock_in & ~s_reg.rclk_d; // RL9
	assign rclk_turn = read_clock_in ^ s_reg.rclk_d;
	assign sclk_rise = serial_clock_in & ~s_reg.sclk_d;
	assign wr_tick = s_reg.cfg.async_wr ? (write_strobe_in & ~s_reg.wstb_d) : wclk_rise;
	assign rd_tick = s_reg.cfg.async_rd ? (read_strobe_in & ~s_reg.rstb_d) : rclk_rise;
	assign ld = ~load_select_n_in;
	assign wr_edge = wr_tick & (s_reg.cfg.async_wr | ~write_enable_n_in); // RL2 RL3
	assign rd_edge = rd_tick & (s_reg.cfg.async_rd | ~read_enable_n_in); // RL4 RL5
	assign in_reset = ~master_reset_n_in | ~partial_reset_n_in;
	assign fifo_full = ~fifo_ready;
	assign ae_cond = (fifo_count <= CNT_W'(s_reg.ofs.empty)); // RL26
	assign af_cond = ((DEPTH_CNT - fifo_count) <= CNT_W'(s_reg.ofs.full)); // RL26

	// ==========================================================
	// Next state
	always_comb begin
		s_next = s_reg;
		push = 1'b0;
		pop = 1'b0;
		mark_req = 1'b0;
		rewind = 1'b0;
		clear = 1'b0;
		wr_word = s_reg.wr_acc;
		s_next.wclk_d = write_clock_in;
		s_next.wstb_d = write_strobe_in;
		s_next.rclk_d = read_clock_in;
		s_next.rstb_d = read_strobe_in;
		s_next.sclk_d = serial_clock_in;
		s_next.rd_evt_d = rd_tick;
		s_next.wr_evt_d = wr_tick;

		// Chip select taken on the read clock, output enable acts directly
		if (rclk_rise) begin
			s_next.rcs_n = read_chip_select_n_in; // RL7
		end
		s_next.oe = ~s_next.rcs_n & ~output_enable_n_in; // RL7

		if (s_reg.cfg.async_rd) begin
			s_next.echo_read_enable = 1'b1; // RL8
			s_next.echo_read_clock = 1'b0; // RL8
		end else begin
			s_next.echo_read_clock = read_clock_in; // RL8
			if (rclk_rise) begin
				s_next.echo_read_enable = read_enable_n_in; // RL8
			end
		end

		// Primary flags change meaning with the timing mode
		if (s_reg.cfg.fall_through) begin
			s_next.ef = ~s_reg.held; // RL13
			s_next.ff = fifo_full; // RL13
		end else begin
			s_next.ef = (fifo_count != '0); // RL13
			s_next.ff = ~fifo_full; // RL13
		end
		s_next.hf = ~(fifo_count > HALF_CNT); // RL13

		// Events are a cycle old so the count already reflects them
		if (s_reg.cfg.flag_sync) begin
			if (s_reg.rd_evt_d) begin
				s_next.almost_empty_flag = ~ae_cond; // RL21
			end
			if (s_reg.wr_evt_d) begin
				s_next.almost_full_flag = ~af_cond; // RL21
			end
		end else begin
			if (s_reg.rd_evt_d && ae_cond) begin
				s_next.almost_empty_flag = 1'b0; // RL20
			end else if (s_reg.wr_evt_d && !ae_cond) begin
				s_next.almost_empty_flag = 1'b1; // RL20
			end
			if (s_reg.wr_evt_d && af_cond) begin
				s_next.almost_full_flag = 1'b0; // RL20
			end else if (s_reg.rd_evt_d && !af_cond) begin
				s_next.almost_full_flag = 1'b1; // RL20
			end
		end

		if (in_reset) begin
			clear = 1'b1; // RL18 RL19
			s_next.wr_part = '0;
			s_next.held = 1'b0;
			s_next.rd_part = '0;
			s_next.ft = FT_IDLE;
			s_next.ft_trans = '0;
			s_next.almost_empty_flag = 1'b0;
			s_next.almost_full_flag = 1'b1;
			if (!master_reset_n_in) begin
				s_next.cfg.in_w = (!bus_match_sel_in || !input_width_sel_in) ? WID_36 :
					(output_width_sel_in ? WID_9 : WID_18); // RL1
				s_next.cfg.out_w = (!bus_match_sel_in || input_width_sel_in) ? WID_36 :
					(output_width_sel_in ? WID_9 : WID_18); // RL1
				// Asynchronous reads cannot fall through
				s_next.cfg.fall_through = fall_through_or_serial_in_in
					& read_port_sync_sel_in; // RL12
				s_next.cfg.async_wr = ~write_port_sync_sel_in;
				s_next.cfg.async_rd = ~read_port_sync_sel_in;
				s_next.cfg.flag_sync = flag_timing_sel_in; // RL22
				s_next.cfg.little_endian = endian_sel_in; // RL23
				s_next.ofs.empty = DEF_OFS[{load_select_n_in, default_offset_sel1_in,
					default_offset_sel0_in}]; // RL14
				s_next.ofs.full = s_next.ofs.empty; // RL14
			end
		end else begin
			// Write port: offsets in parallel, or data into the buffer
			if (wclk_rise && !write_enable_n_in && ld && !s_reg.cfg.async_wr) begin
				s_next.ofs.empty = data_in_in[OFS_EMPTY_LSB +: OFS_W]; // RL16
				s_next.ofs.full = data_in_in[OFS_FULL_LSB +: OFS_W]; // RL16
			end else if (wr_edge && !ld && fifo_ready) begin // RL25
				wr_word = bmf_slice_put(s_reg.wr_acc, data_in_in, s_reg.cfg.in_w,
					s_reg.wr_part, s_reg.cfg.little_endian);
				s_next.wr_acc = wr_word;
				if (s_reg.wr_part == bmf_last_part(s_reg.cfg.in_w)) begin
					push = 1'b1; // RL2 RL3
					s_next.wr_part = '0;
				end else begin
					s_next.wr_part = 2'(s_reg.wr_part + 2'h1);
				end
			end

			if (sclk_rise && !serial_load_enable_n_in && ld) begin
				s_next.ofs = bmf_ofs_t'({s_reg.ofs[2*OFS_W-2:0],
					fall_through_or_serial_in_in}); // RL15
			end

			// Read port
			if (rd_tick && mark_in) begin
				mark_req = 1'b1; // RL24
			end
			if (rd_tick && !retransmit_n_in) begin
				rewind = 1'b1; // RL24
				s_next.held = 1'b0;
				s_next.rd_part = '0;
				s_next.ft_trans = '0;
				s_next.ft = FT_IDLE;
			end else if (rd_edge && ld) begin
				s_next.dout = '0;
				s_next.dout[OFS_EMPTY_LSB +: OFS_W] = s_reg.ofs.empty; // RL17
				s_next.dout[OFS_FULL_LSB +: OFS_W] = s_reg.ofs.full; // RL17
			end else if (s_reg.cfg.fall_through && !s_reg.held) begin
				// First word falls through without a read request
				if (fifo_valid && rclk_turn) begin
					s_next.ft = FT_ARMED;
					s_next.ft_trans = 2'(s_reg.ft_trans + 2'h1);
					if (2'(s_reg.ft_trans + 2'h1) == FT_TRANSITIONS) begin // RL11
						pop = 1'b1;
						s_next.hold = fifo_data;
						s_next.held = 1'b1;
						s_next.rd_part = '0;
						s_next.dout = bmf_slice_get(fifo_data, s_reg.cfg.out_w, 2'h0,
							s_reg.cfg.little_endian); // RL23
						s_next.ft = FT_IDLE;
						s_next.ft_trans = '0;
					end
				end
			end else if (rd_edge) begin // RL10
				if (s_reg.held && s_reg.rd_part != bmf_last_part(s_reg.cfg.out_w)) begin
					s_next.rd_part = 2'(s_reg.rd_part + 2'h1);
					s_next.dout = bmf_slice_get(s_reg.hold, s_reg.cfg.out_w,
						s_next.rd_part, s_reg.cfg.little_endian); // RL23
				end else if (fifo_valid) begin // RL25
					pop = 1'b1; // RL4 RL5
					s_next.hold = fifo_data;
					s_next.held = 1'b1;
					s_next.rd_part = '0;
					s_next.dout = bmf_slice_get(fifo_data, s_reg.cfg.out_w, 2'h0,
						s_reg.cfg.little_endian); // RL23
				end else if (s_reg.cfg.fall_through) begin
					s_next.held = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_reg <= '0;
			s_reg.ff <= 1'b1;
			s_reg.hf <= 1'b1;
			s_reg.almost_full_flag <= 1'b1;
			s_reg.echo_read_enable <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// ==========================================================
	// Storage; writes that reach a full buffer are dropped
	bmf_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.clear_in(clear),
		.mark_in(mark_req),
		.rewind_in(rewind),
		.in_valid_in(push),
		.in_ready_out(fifo_ready),
		.in_data_in(wr_word),
		.out_valid_out(fifo_valid),
		.out_ready_in(pop),
		.out_data_out(fifo_data),
		.count_out(fifo_count)
	);

	assign data_out_out = s_reg.dout;
	assign data_out_oe_out = s_reg.oe;
	assign echo_read_enable_n_out = s_reg.echo_read_enable;
	assign echo_read_clock_out = s_reg.echo_read_clock;
	assign empty_flag_n_out = s_reg.ef;
	assign full_flag_n_out = s_reg.ff;
	assign half_full_flag_n_out = s_reg.hf;
	assign almost_empty_flag_n_out = s_reg.almost_empty_flag;
	assign almost_full_flag_n_out = s_reg.almost_full_flag;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence seq_ft_waiting;
		master_reset_n_in && partial_reset_n_in && s_reg.cfg.fall_through && !s_reg.held;
	endsequence

	sequence seq_ft_third_turn;
		seq_ft_waiting ##0 (fifo_valid && rclk_turn && retransmit_n_in && !(rd_edge && ld)
			&& s_reg.ft_trans == 2'h2);
	endsequence

	a_oe_async_off: assert property (output_enable_n_in |=> !data_out_oe_out) // RL7
		else $error("outputs driven while output enable inactive");
	a_rcs_sampled: assert property (rclk_rise && read_chip_select_n_in
		##1 !rclk_rise |-> ##1 !data_out_oe_out) // RL7
		else $error("outputs driven after chip select sampled off");
	a_ft_show_word: assert property (seq_ft_third_turn |=> s_reg.held ##1 !empty_flag_n_out) // RL11
		else $error("first word did not fall through on third transition");
	a_std_needs_read: assert property (master_reset_n_in && partial_reset_n_in
		&& !s_reg.cfg.fall_through && !s_reg.held && !rd_edge |=> !s_reg.held) // RL10
		else $error("standard mode showed a word without a read");
	a_full_write_drop: assert property (master_reset_n_in && partial_reset_n_in && wr_edge
		&& !ld && fifo_full && !pop && !rewind |=> fifo_count == DEPTH_CNT) // RL25
		else $error("write accepted while full");
	a_empty_read_drop: assert property (master_reset_n_in && partial_reset_n_in
		&& !fifo_valid && !push && !rewind |=> fifo_count == '0) // RL25
		else $error("read taken while empty");
	a_echo_idle: assert property (s_reg.cfg.async_rd |=> echo_read_enable_n_out
		&& !echo_read_clock_out) // RL8
		else $error("echo outputs active in asynchronous read mode");
	a_mrs_pointers: assert property (!master_reset_n_in |=> fifo_count == '0) // RL18
		else $error("pointers not cleared by master reset");
	a_prs_keeps: assert property (master_reset_n_in && !partial_reset_n_in
		|=> $stable(s_reg.cfg) && $stable(s_reg.ofs) && fifo_count == '0) // RL19
		else $error("partial reset lost settings or kept data");
	a_sync_pae_hold: assert property (master_reset_n_in && partial_reset_n_in
		&& s_reg.cfg.flag_sync && !s_reg.rd_evt_d |=> $stable(almost_empty_flag_n_out)) // RL21
		else $error("almost-empty moved without a read edge");
	a_default_ofs: assert property (!master_reset_n_in |=> s_reg.ofs.empty
		== DEF_OFS[$past({load_select_n_in, default_offset_sel1_in,
		default_offset_sel0_in})]) // RL14
		else $error("default offset not taken at master reset");
endmodule // bmf_top
`default_nettype wire

// ==== logic/bmf_pkg.sv ====
`default_nettype none
package bmf_pkg;

	// ==========================================================
	// Widths and depth
	localparam int WORD_W = 36;
	localparam int HALF_W = 18;
	localparam int BYTE_W = 9;
	localparam int FIFO_DEPTH = 8;
	localparam int CNT_W = 4;
	localparam int OFS_W = 3;
	localparam logic [CNT_W-1:0] DEPTH_CNT = 4'h8;
	localparam logic [CNT_W-1:0] HALF_CNT = 4'h4;

	// ==========================================================
	// Offset field positions on the data buses
	localparam int OFS_EMPTY_LSB = 0;
	localparam int OFS_FULL_LSB = 18;

	// ==========================================================
	// Timing and part counts
	localparam logic [1:0] FT_TRANSITIONS = 2'h3;
	localparam logic [1:0] LAST_PART_36 = 2'h0;
	localparam logic [1:0] LAST_PART_18 = 2'h1;
	localparam logic [1:0] LAST_PART_9 = 2'h3;

	// Defaults indexed by {load select, sel1, sel0}
	localparam logic [7:0][OFS_W-1:0] DEF_OFS = {3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};

	// ==========================================================
	// Types
	typedef enum logic [1:0] {WID_36, WID_18, WID_9} bmf_width_t;
	typedef enum logic {FT_IDLE, FT_ARMED} bmf_ft_t;

	typedef struct packed {
		bmf_width_t in_w;
		bmf_width_t out_w;
		logic fall_through;
		logic async_wr;
		logic async_rd;
		logic flag_sync;
		logic little_endian;
	} bmf_cfg_t;

	typedef struct packed {
		logic [OFS_W-1:0] full;
		logic [OFS_W-1:0] empty;
	} bmf_ofs_t;

	// ==========================================================
	// Bus matching helpers
	function automatic logic [1:0] bmf_last_part(input bmf_width_t w);
		case (w)
			WID_18: return LAST_PART_18;
			WID_9: return LAST_PART_9;
			default: return LAST_PART_36;
		endcase
	endfunction

	function automatic logic [1:0] bmf_lane(input bmf_width_t w, input logic [1:0] part,
			input logic little);
		return little ? part : 2'(bmf_last_part(w) - part);
	endfunction

	function automatic logic [WORD_W-1:0] bmf_slice_get(input logic [WORD_W-1:0] word,
			input bmf_width_t w, input logic [1:0] part, input logic little);
		logic [1:0] k;
		logic [WORD_W-1:0] r;
		k = bmf_lane(w, part, little);
		r = '0;
		case (w)
			WID_18: r[HALF_W-1:0] = word[k[0]*HALF_W +: HALF_W];
			WID_9: r[BYTE_W-1:0] = word[k*BYTE_W +: BYTE_W];
			default: r = word;
		endcase
		return r;
	endfunction

	function automatic logic [WORD_W-1:0] bmf_slice_put(input logic [WORD_W-1:0] acc,
			input logic [WORD_W-1:0] din, input bmf_width_t w, input logic [1:0] part,
			input logic little);
		logic [1:0] k;
		logic [WORD_W-1:0] r;
		k = bmf_lane(w, part, little);
		r = acc;
		case (w)
			WID_18: r[k[0]*HALF_W +: HALF_W] = din[HALF_W-1:0];
			WID_9: r[k*BYTE_W +: BYTE_W] = din[BYTE_W-1:0];
			default: r = din;
		endcase
		return r;
	endfunction

endpackage
`default_nettype wire

// ==== logic/bmf_top_note_removed.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== bench/bmf_partner.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Producer and consumer on the two ports
module bmf_partner import bmf_pkg::*; (
	// Clock
	input wire logic clk_in,
	// Write side
	output logic wclk_out,
	output logic wen_n_out,
	output logic [WORD_W-1:0] din_out,
	// Read side
	output logic rclk_out,
	output logic ren_n_out,
	output logic mark_out,
	output logic rt_n_out,
	// Serial offset side
	output logic sclk_out,
	output logic sen_n_out,
	output logic si_out
);
	initial begin
		{wclk_out, rclk_out, sclk_out, mark_out, si_out} = '0;
		{wen_n_out, ren_n_out, rt_n_out, sen_n_out} = '1;
		din_out = '0;
	end

	task automatic set_si(input logic v);
		@(posedge clk_in) si_out <= v;
	endtask

	// One rise per chosen clock, high for one sample, then low
	task automatic pulse(input logic [2:0] c, input logic wn, input logic rn,
			input logic [WORD_W-1:0] d, input logic mk, input logic rtn);
		@(posedge clk_in);
		{sclk_out, rclk_out, wclk_out} <= c;
		wen_n_out <= wn;
		ren_n_out <= rn;
		din_out <= d;
		mark_out <= mk;
		rt_n_out <= rtn;
		sen_n_out <= ~c[2];
		if (c[2]) si_out <= d[0];
		@(posedge clk_in);
		{sclk_out, rclk_out, wclk_out} <= 3'h0;
		{wen_n_out, ren_n_out, rt_n_out, sen_n_out} <= 4'hf;
		mark_out <= 1'b0;
		// Released bus shows the inverse, not a stale word
		din_out <= ~d;
	endtask
endmodule // bmf_partner

`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb import bmf_pkg::*; ();
	localparam logic [WORD_W-1:0] BASE = 36'h0a5a50000;
	localparam logic [WORD_W-1:0] BASE2 = 36'h123456789;
	localparam logic [5:0] SER = 6'h33;
	logic clk, rst_n, mr_n, pr_n, iw, ow, bm, be, s0, s1, ld_n, cs_n, oe_n;
	logic ws, rs, wstb, rstb;
	wire logic wclk, wen_n, rclk, ren_n, mk, rt_n, sclk, sen_n, si;
	wire logic [WORD_W-1:0] din, q;
	wire logic oe, een_n, eclk, ef_n, ff_n, hf_n, ae_n, af_n;
	int miscompares, samples_checked, lane;

	bmf_partner p (.clk_in(clk), .wclk_out(wclk), .wen_n_out(wen_n), .din_out(din),
		.rclk_out(rclk), .ren_n_out(ren_n), .mark_out(mk), .rt_n_out(rt_n),
		.sclk_out(sclk), .sen_n_out(sen_n), .si_out(si));

	// Flag timing stays synchronous throughout
	bmf_top dut (.clk_in(clk), .rst_n_in(rst_n), .master_reset_n_in(mr_n),
		.partial_reset_n_in(pr_n), .input_width_sel_in(iw), .output_width_sel_in(ow),
		.bus_match_sel_in(bm), .endian_sel_in(be), .flag_timing_sel_in(1'b1),
		.write_port_sync_sel_in(ws), .read_port_sync_sel_in(rs),
		.default_offset_sel0_in(s0), .default_offset_sel1_in(s1),
		.write_clock_in(wclk), .write_enable_n_in(wen_n), .write_strobe_in(wstb),
		.data_in_in(din), .read_clock_in(rclk), .read_enable_n_in(ren_n),
		.read_strobe_in(rstb), .read_chip_select_n_in(cs_n), .output_enable_n_in(oe_n),
		.mark_in(mk), .retransmit_n_in(rt_n), .load_select_n_in(ld_n),
		.serial_clock_in(sclk), .serial_load_enable_n_in(sen_n),
		.fall_through_or_serial_in_in(si), .data_out_out(q), .data_out_oe_out(oe),
		.echo_read_enable_n_out(een_n), .echo_read_clock_out(eclk),
		.empty_flag_n_out(ef_n), .full_flag_n_out(ff_n), .half_full_flag_n_out(hf_n),
		.almost_empty_flag_n_out(ae_n), .almost_full_flag_n_out(af_n));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic end_sim;
		if (miscompares == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk_w(input string n, input logic [WORD_W-1:0] e, input logic [WORD_W-1:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk_b(input string n, input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("FAIL %s expected %b seen %b", n, e, g);
		end
	endtask

	// Settle past the edge so flop updates have landed
	task automatic waitc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [WORD_W-1:0] d);
		p.pulse(3'h1, 1'b0, 1'b1, d, 1'b0, 1'b1);
	endtask

	task automatic rd;
		p.pulse(3'h2, 1'b1, 1'b0, '0, 1'b0, 1'b1);
		waitc(3);
	endtask

	task automatic mreset(input logic b, input logic i, input logic o, input logic e,
			input logic f);
		p.set_si(f);
		@(posedge clk);
		{bm, iw, ow, be, s0, s1} <= {b, i, o, e, e, f};
		mr_n <= 1'b0;
		waitc(3);
		@(posedge clk) mr_n <= 1'b1;
		waitc(1);
	endtask

	initial begin
		#(25 * 20000);
		miscompares++;
		end_sim();
	end

	initial begin
		{rst_n, iw, ow, bm, be, s0, s1, cs_n, oe_n} = '0;
		{mr_n, pr_n, ld_n} = 3'h7;
		{ws, rs} = 2'h3;
		{wstb, rstb} = 2'h0;
		miscompares = 0;
		samples_checked = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		waitc(1);
		chk_b("full", 1'b1, ff_n);
		mreset(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		// Ninth word meets a full buffer
		for (int i = 0; i < 9; i++) wr(BASE + 36'(i));
		waitc(4);
		chk_w("q idle", '0, q);
		chk_b("full", 1'b0, ff_n);
		chk_b("half", 1'b0, hf_n);
		chk_b("afull", 1'b0, af_n);
		chk_b("aempty", 1'b0, ae_n);
		for (int i = 0; i < 8; i++) begin
			rd();
			chk_w("q", BASE + 36'(i), q);
			if (i == 0) chk_b("aempty", 1'b1, ae_n);
		end
		rd();
		chk_w("q held", BASE + 36'h7, q);
		chk_b("empty", 1'b0, ef_n);
		@(posedge clk) ld_n <= 1'b0;
		rd();
		chk_w("ofs", 36'h000100004, q);
		wr(36'h000080001);
		rd();
		chk_w("ofs", 36'h000080001, q);
		for (int k = 5; k >= 0; k--) p.pulse(3'h4, 1'b1, 1'b1, 36'(SER[k]), 1'b0, 1'b1);
		rd();
		chk_w("ofs", 36'h000180003, q);
		@(posedge clk) ld_n <= 1'b1;
		wr(BASE);
		wr(BASE);
		waitc(4);
		chk_b("empty", 1'b1, ef_n);
		@(posedge clk) pr_n <= 1'b0;
		waitc(3);
		@(posedge clk) pr_n <= 1'b1;
		waitc(4);
		chk_b("empty", 1'b0, ef_n);
		@(posedge clk) ld_n <= 1'b0;
		rd();
		chk_w("ofs", 36'h000180003, q);
		@(posedge clk) ld_n <= 1'b1;
		for (int i = 0; i < 3; i++) wr(BASE2 + 36'(i));
		p.pulse(3'h2, 1'b1, 1'b1, '0, 1'b1, 1'b1);
		rd();
		rd();
		p.pulse(3'h2, 1'b1, 1'b1, '0, 1'b0, 1'b0);
		rd();
		chk_w("rewind", BASE2, q);
		chk_b("echo en", 1'b0, een_n);
		chk_b("oe", 1'b1, oe);
		@(posedge clk) oe_n <= 1'b1;
		waitc(3);
		chk_b("oe", 1'b0, oe);
		@(posedge clk);
		oe_n <= 1'b0;
		cs_n <= 1'b1;
		p.pulse(3'h2, 1'b1, 1'b1, '0, 1'b0, 1'b1);
		waitc(3);
		chk_b("oe", 1'b0, oe);
		@(posedge clk) cs_n <= 1'b0;
		for (int e = 0; e < 2; e++) begin
			mreset(1'b1, 1'b0, 1'b1, 1'(e), 1'b0);
			wr(BASE2);
			for (int k = 0; k < 4; k++) begin
				rd();
				lane = (e == 1) ? k : 3 - k;
				chk_w("narrow", {27'h0, BASE2[lane*BYTE_W +: BYTE_W]}, q);
			end
		end
		mreset(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
		wr(BASE);
		waitc(4);
		chk_b("ready", 1'b1, ef_n);
		repeat (2) p.pulse(3'h2, 1'b1, 1'b1, '0, 1'b0, 1'b1);
		waitc(4);
		chk_w("ft", BASE, q);
		chk_b("ready", 1'b0, ef_n);
		// Strobe ports; chip select kept low and standard mode chosen
		@(posedge clk) {ws, rs} <= 2'h0;
		mreset(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		@(posedge clk) wstb <= 1'b1;
		@(posedge clk) wstb <= 1'b0;
		@(posedge clk) rstb <= 1'b1;
		@(posedge clk) rstb <= 1'b0;
		waitc(3);
		chk_w("strobe", 36'hfffffffff, q);
		chk_b("echo en", 1'b1, een_n);
		chk_b("echo clk", 1'b0, eclk);
		end_sim();
	end
endmodule // tb

`default_nettype wire
